// ### src/speed_profile_mode.sv
/*
 * Operating-mode logic: speed-profile generator with status evaluation and the
 * entry logic of the reference run.
 * Assumes synchronous inputs on sys_clk_i and a host that keeps its own rules.
 */
`timescale 1ns/10ps
`default_nettype none

module speed_profile_mode (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic signed [15:0] actual_speed_i,
  input wire logic [3:0] dig_in_i,
  input wire logic travel_sup_en_i,
  input wire logic ffwd_en_i,
  output logic [15:0] rdata_o,
  output logic signed [15:0] demand_speed_o,
  output logic signed [15:0] torque_ffwd_o,
  output logic pos_zero_o
);

  // ********************************************************************
  // Types and shared functions
  // ********************************************************************
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_RUN = 4'h2,
    H_DONE = 4'h4,
    H_ERR = 4'h8
  } home_state_t;

  function automatic logic signed [15:0] scale(input logic signed [15:0] v, input logic [15:0] f);
    logic signed [32:0] p;
    p = v * $signed({1'b0, f});
    return p[23:8];
  endfunction : scale

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  speed_profile_pkg::reg_req_t req;
  speed_profile_pkg::switch_in_t sw;
  logic [7:0] mode_reg;
  logic [15:0] ctrl_reg;
  logic signed [15:0] target_reg;
  logic [15:0] accel_reg, decel_reg, vwin_reg, vwin_time_reg, thresh_reg, max_dev_reg, scale_reg;
  logic [15:0] home_accel_reg, home_speed_reg, input_map_reg;
  logic prof_type_reg;
  logic signed [7:0] method_reg;
  logic signed [15:0] demand_reg, demand_next;
  logic [15:0] status_reg, status_next;
  logic [7:0] mode_prev_reg;
  logic [15:0] win_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic start_prev_reg;
  logic limit_hold_reg;
  home_state_t home_reg;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign sw = speed_profile_pkg::switch_in_t'(dig_in_i);

  // ********************************************************************
  // Register file
  // ********************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_reg <= 8'h00;
      ctrl_reg <= 16'h0000;
      target_reg <= 16'sh0000;
      accel_reg <= speed_profile_pkg::RST_ACCEL;
      decel_reg <= speed_profile_pkg::RST_ACCEL;
      prof_type_reg <= speed_profile_pkg::PROF_TRAPEZOID;
      vwin_reg <= speed_profile_pkg::RST_VWIN;
      vwin_time_reg <= speed_profile_pkg::RST_VWIN_TIME;
      thresh_reg <= speed_profile_pkg::RST_THRESH;
      max_dev_reg <= speed_profile_pkg::RST_MAX_DEV;
      scale_reg <= speed_profile_pkg::RST_SCALE;
      method_reg <= 8'sh00;
      home_accel_reg <= speed_profile_pkg::RST_ACCEL;
      home_speed_reg <= speed_profile_pkg::RST_HOME_SPEED;
      input_map_reg <= speed_profile_pkg::RST_INPUT_MAP;
    end else if (req.wr) begin
      unique case (req.addr)
        speed_profile_pkg::OFS_MODE: mode_reg <= req.wdata[7:0];
        speed_profile_pkg::OFS_CTRL: ctrl_reg <= req.wdata;
        speed_profile_pkg::OFS_TARGET: target_reg <= scale(req.wdata, scale_reg);
        speed_profile_pkg::OFS_ACCEL: accel_reg <= req.wdata;
        speed_profile_pkg::OFS_DECEL: decel_reg <= req.wdata;
        speed_profile_pkg::OFS_PROF_TYPE: prof_type_reg <= req.wdata[0];
        speed_profile_pkg::OFS_VWIN: vwin_reg <= req.wdata;
        speed_profile_pkg::OFS_VWIN_TIME: vwin_time_reg <= req.wdata;
        speed_profile_pkg::OFS_THRESH: thresh_reg <= req.wdata;
        speed_profile_pkg::OFS_MAX_DEV: max_dev_reg <= req.wdata;
        speed_profile_pkg::OFS_SCALE: scale_reg <= req.wdata;
        speed_profile_pkg::OFS_HOME_METHOD: method_reg <= req.wdata[7:0];
        speed_profile_pkg::OFS_HOME_ACCEL: home_accel_reg <= req.wdata;
        speed_profile_pkg::OFS_HOME_SPEED: home_speed_reg <= req.wdata;
        speed_profile_pkg::OFS_INPUT_MAP: input_map_reg <= req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        speed_profile_pkg::OFS_MODE: rdata_o <= {8'h00, mode_reg};
        speed_profile_pkg::OFS_CTRL: rdata_o <= ctrl_reg;
        speed_profile_pkg::OFS_TARGET: rdata_o <= target_reg;
        speed_profile_pkg::OFS_ACCEL: rdata_o <= accel_reg;
        speed_profile_pkg::OFS_DECEL: rdata_o <= decel_reg;
        speed_profile_pkg::OFS_PROF_TYPE: rdata_o <= {15'h0000, prof_type_reg};
        speed_profile_pkg::OFS_VWIN: rdata_o <= vwin_reg;
        speed_profile_pkg::OFS_VWIN_TIME: rdata_o <= vwin_time_reg;
        speed_profile_pkg::OFS_THRESH: rdata_o <= thresh_reg;
        speed_profile_pkg::OFS_MAX_DEV: rdata_o <= max_dev_reg;
        speed_profile_pkg::OFS_SCALE: rdata_o <= scale_reg;
        speed_profile_pkg::OFS_HOME_METHOD: rdata_o <= {{8{method_reg[7]}}, method_reg};
        speed_profile_pkg::OFS_HOME_ACCEL: rdata_o <= home_accel_reg;
        speed_profile_pkg::OFS_HOME_SPEED: rdata_o <= home_speed_reg;
        speed_profile_pkg::OFS_INPUT_MAP: rdata_o <= input_map_reg;
        speed_profile_pkg::OFS_STATUS: rdata_o <= status_reg;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ********************************************************************
  // Scaled actual speed and switch decoding
  // ********************************************************************
  logic signed [15:0] act_scaled;
  logic in_pv, in_home, stage_on, halt, limit_pos, limit_neg, ref_sw, idx;
  assign act_scaled = scale(actual_speed_i, scale_reg);
  assign in_pv = (mode_reg == speed_profile_pkg::MODE_SPEED_PROFILE);
  assign in_home = (mode_reg == speed_profile_pkg::MODE_HOMING);
  assign stage_on = ctrl_reg[speed_profile_pkg::CTRL_ENABLE_BIT];
  assign halt = ctrl_reg[speed_profile_pkg::CTRL_HALT_BIT];
  // The low three nibbles of the input map pick the inputs for positive limit, negative limit and reference switch.
  assign limit_pos = dig_in_i[input_map_reg[1:0]];
  assign limit_neg = dig_in_i[input_map_reg[5:4]];
  assign ref_sw = dig_in_i[input_map_reg[9:8]];
  assign idx = sw.index;

  // ********************************************************************
  // Profile generator
  // ********************************************************************
  logic signed [15:0] goal;
  logic [15:0] step_up, step_dn, step;
  logic method_switch, method_stop, method_zero, start_edge;
  assign method_switch = (method_reg >= speed_profile_pkg::METHOD_SWITCH_LO) &&
                         (method_reg <= speed_profile_pkg::METHOD_SWITCH_HI);
  assign method_stop = (method_reg >= speed_profile_pkg::METHOD_STOP_LO) &&
                       (method_reg <= speed_profile_pkg::METHOD_STOP_HI);
  assign method_zero = (method_reg == speed_profile_pkg::METHOD_SET_ZERO);
  assign start_edge = in_home && ctrl_reg[speed_profile_pkg::CTRL_HOME_START_BIT] && !start_prev_reg;

  always_comb begin
    goal = 16'sh0000;
    if (in_pv && stage_on && !halt && !limit_hold_reg) begin
      goal = target_reg;
    end else if (in_home && stage_on && !halt && home_reg == H_RUN) begin
      // The reference run travels at its own speed; odd methods go negative, even ones positive.
      goal = method_reg[0] ? $signed(16'(-home_speed_reg)) : $signed(home_speed_reg);
    end
  end

  always_comb begin
    step_up = in_home ? home_accel_reg : accel_reg;
    step_dn = in_home ? home_accel_reg : decel_reg;
    demand_next = demand_reg;
    // Moving away from zero accelerates, toward zero brakes; a sign change passes zero.
    if (demand_reg != 16'sh0000 && (goal[15] != demand_reg[15] || mag(goal) < mag(demand_reg))) begin
      step = step_dn;
    end else begin
      step = step_up;
    end
    // Sine-squared shaping softens the ramp near the goal by halving the step.
    if (prof_type_reg == speed_profile_pkg::PROF_SINE_SQ &&
        {2'b00, mag(16'(goal - demand_reg))} < {step, 2'b00}) begin
      step = (step >> 1) | 16'h0001;
    end
    if (goal > demand_reg) begin
      if (demand_reg[15] && !goal[15] && (17'(mag(demand_reg)) <= 17'(step))) begin
        demand_next = 16'sh0000;
      end else if (17'(goal) - 17'(demand_reg) <= 17'(step)) begin
        demand_next = goal;
      end else begin
        demand_next = 16'(demand_reg + $signed(step));
      end
    end else if (goal < demand_reg) begin
      if (goal[15] && !demand_reg[15] && demand_reg != 16'sh0000 && (17'(demand_reg) <= 17'(step))) begin
        demand_next = 16'sh0000;
      end else if (17'(demand_reg) - 17'(goal) <= 17'(step)) begin
        demand_next = goal;
      end else begin
        demand_next = 16'(demand_reg - $signed(step));
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      demand_reg <= 16'sh0000;
      demand_speed_o <= 16'sh0000;
      torque_ffwd_o <= 16'sh0000;
    end else begin
      demand_reg <= demand_next;
      demand_speed_o <= demand_next;
      torque_ffwd_o <= ffwd_en_i ? 16'(demand_next - demand_reg) : 16'sh0000;
    end
  end

  // ********************************************************************
  // Travel supervision
  // ********************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      limit_hold_reg <= 1'b0;
    end else begin
      limit_hold_reg <= travel_sup_en_i && in_pv &&
                        ((limit_pos && !target_reg[15]) || (limit_neg && target_reg[15]));
    end
  end

  // ********************************************************************
  // Velocity window timer
  // ********************************************************************
  logic in_window, at_rest, dev_hit;
  assign in_window = mag(16'(act_scaled - target_reg)) <= vwin_reg;
  assign at_rest = mag(act_scaled) <= thresh_reg;
  assign dev_hit = mag(16'(demand_reg - act_scaled)) >= max_dev_reg;
  assign tick = (tick_cnt_reg == 32'(speed_profile_pkg::TICK_CYCLES - 1));

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_cnt_reg <= 16'h0000;
    end else if (!in_window || mode_reg != mode_prev_reg) begin
      win_cnt_reg <= 16'h0000;
    end else if (tick && win_cnt_reg < vwin_time_reg) begin
      win_cnt_reg <= win_cnt_reg + 16'h0001;
    end
  end

  // ********************************************************************
  // Reference run
  // ********************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      home_reg <= H_IDLE;
      start_prev_reg <= 1'b0;
      pos_zero_o <= 1'b0;
    end else begin
      start_prev_reg <= ctrl_reg[speed_profile_pkg::CTRL_HOME_START_BIT];
      pos_zero_o <= 1'b0;
      if (!in_home || !ctrl_reg[speed_profile_pkg::CTRL_HOME_START_BIT]) begin
        home_reg <= H_IDLE;
      end else begin
        unique case (home_reg)
          H_IDLE: begin
            if (start_edge && method_zero) begin
              pos_zero_o <= 1'b1;
              home_reg <= H_DONE;
            end else if (start_edge && (method_switch || method_stop)) begin
              home_reg <= H_RUN;
            end
          end
          H_RUN: begin
            if (method_switch && (method_reg[0] ? limit_pos : limit_neg)) begin
              home_reg <= H_ERR;
            end else if (method_switch && (ref_sw || (method_reg[0] ? limit_neg : limit_pos)) &&
                         (idx || method_reg > 8'sh10)) begin
              pos_zero_o <= 1'b1;
              home_reg <= H_DONE;
            end else if (method_stop && dev_hit) begin
              pos_zero_o <= 1'b1;
              home_reg <= H_DONE;
            end
          end
          H_DONE: home_reg <= H_DONE;
          H_ERR: home_reg <= H_ERR;
        endcase
      end
    end
  end

  // ********************************************************************
  // Status word
  // ********************************************************************
  always_comb begin
    status_next = 16'h0000;
    if (mode_reg != mode_prev_reg) begin
      status_next = 16'h0000;
    end else if (in_pv) begin
      // Control bits beyond halt and enable carry no meaning here.
      status_next[speed_profile_pkg::ST_REACHED_BIT] = halt ? at_rest :
        (in_window && win_cnt_reg >= vwin_time_reg);
      status_next[speed_profile_pkg::ST_ZERO_BIT] = at_rest;
      status_next[speed_profile_pkg::ST_DEV_BIT] = dev_hit;
    end else if (in_home) begin
      status_next[speed_profile_pkg::ST_REACHED_BIT] = (home_reg != H_RUN) && at_rest;
      status_next[speed_profile_pkg::ST_ZERO_BIT] = (home_reg == H_DONE);
      status_next[speed_profile_pkg::ST_DEV_BIT] = (home_reg == H_ERR);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_reg <= 16'h0000;
      mode_prev_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
      mode_prev_reg <= mode_reg;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_reach_needs_time: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (in_pv && !halt && status_next[10]) |-> win_cnt_reg >= vwin_time_reg) else $error("reached too early");
  a_window_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!in_window) |=> win_cnt_reg == 16'h0000) else $error("window timer kept");
  a_rest_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (in_pv && $stable(mode_reg)) |=> status_reg[12] == $past(at_rest)) else $error("standstill bit wrong");
  a_dev_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (in_pv && $stable(mode_reg)) |=> status_reg[13] == $past(dev_hit)) else $error("deviation bit wrong");
  a_mode_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mode_reg != mode_prev_reg) |=> status_reg == 16'h0000) else $error("status not cleared");
  a_zero_no_move: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (home_reg == H_IDLE && start_edge && method_zero) |=> pos_zero_o && home_reg == H_DONE) else $error("zero");
  a_err_stays: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (home_reg == H_ERR && in_home && ctrl_reg[4]) |=> home_reg == H_ERR) else $error("error left");
  a_ramp_limit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (in_pv) |=> mag(16'(demand_reg - $past(demand_reg))) <= (accel_reg > decel_reg ? accel_reg : decel_reg))
    else $error("ramp too steep");
  a_no_start: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (home_reg == H_IDLE && !ctrl_reg[4]) |=> home_reg == H_IDLE) else $error("run without start");
  c_reached: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) in_pv && status_reg[10]);
  c_reverse: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) demand_reg[15] ##[1:200] demand_reg > 0);
  c_home_done: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) home_reg == H_DONE);
  c_home_error: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) home_reg == H_ERR);

endmodule : speed_profile_mode

`default_nettype wire

// ### src/speed_profile_pkg.sv
/*
 * Constants and carrier types for the speed-profile and reference-run mode logic.
 * Assumes a single clock domain and a simple word-wide register port.
 */
package speed_profile_pkg;

  // ********************************************************************
  // Register offsets (word indices on the plain register port)
  // ********************************************************************
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_TARGET = 4'h2;
  localparam logic [3:0] OFS_ACCEL = 4'h3;
  localparam logic [3:0] OFS_DECEL = 4'h4;
  localparam logic [3:0] OFS_PROF_TYPE = 4'h5;
  localparam logic [3:0] OFS_VWIN = 4'h6;
  localparam logic [3:0] OFS_VWIN_TIME = 4'h7;
  localparam logic [3:0] OFS_THRESH = 4'h8;
  localparam logic [3:0] OFS_MAX_DEV = 4'h9;
  localparam logic [3:0] OFS_SCALE = 4'ha;
  localparam logic [3:0] OFS_HOME_METHOD = 4'hb;
  localparam logic [3:0] OFS_HOME_ACCEL = 4'hc;
  localparam logic [3:0] OFS_HOME_SPEED = 4'hd;
  localparam logic [3:0] OFS_INPUT_MAP = 4'he;
  localparam logic [3:0] OFS_STATUS = 4'hf;

  // ********************************************************************
  // Field positions and codes
  // ********************************************************************
  localparam logic [7:0] MODE_SPEED_PROFILE = 8'h03;
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam int CTRL_ENABLE_BIT = 3;
  localparam int CTRL_HOME_START_BIT = 4;
  localparam int CTRL_HALT_BIT = 8;
  localparam int ST_REACHED_BIT = 10;
  localparam int ST_ZERO_BIT = 12;
  localparam int ST_DEV_BIT = 13;
  localparam logic PROF_TRAPEZOID = 1'b0;
  localparam logic PROF_SINE_SQ = 1'b1;
  localparam logic signed [7:0] METHOD_SWITCH_LO = 8'sh01;
  localparam logic signed [7:0] METHOD_SWITCH_HI = 8'sh22;
  localparam logic signed [7:0] METHOD_SET_ZERO = 8'sh25;
  localparam logic signed [7:0] METHOD_STOP_LO = -8'sh04;
  localparam logic signed [7:0] METHOD_STOP_HI = -8'sh01;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [15:0] RST_ACCEL = 16'h0064;
  localparam logic [15:0] RST_SCALE = 16'h0100;
  localparam logic [15:0] RST_VWIN = 16'h0010;
  localparam logic [15:0] RST_VWIN_TIME = 16'h0014;
  localparam logic [15:0] RST_THRESH = 16'h0008;
  localparam logic [15:0] RST_MAX_DEV = 16'h0400;
  localparam logic [15:0] RST_INPUT_MAP = 16'h0210;
  localparam logic [15:0] RST_HOME_SPEED = 16'h0100;

  // Clock rate and the time base of the window timer (1 ms ticks).
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic pos_limit;
    logic neg_limit;
    logic home_sw;
    logic index;
  } switch_in_t;

endpackage : speed_profile_pkg

// ### tb/plant_model.sv
/*
 * Motor stand-in: the actual speed follows the demand when asked, else stands still.
 * Assumes the block's clock and its signed demand value.
 */
`timescale 1ns/10ps
`default_nettype none
module plant_model (
  input wire logic sys_clk_i,
  input wire logic follow_i,
  input wire logic signed [15:0] demand_i,
  output logic signed [15:0] actual_o
);
  always_ff @(posedge sys_clk_i) begin
    actual_o <= follow_i ? demand_i : 16'sh0000;
  end
endmodule : plant_model
`default_nettype wire

// ### tb/tb.sv
/*
 * Self-checking bench for the speed-profile and reference-run mode block.
 * Assumes the plant model drives the measured speed.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic follow = 1'b0;
  logic signed [15:0] act;
  logic signed [15:0] dem;
  logic [15:0] rdata;
  logic pz;
  logic signed [15:0] tq;
  logic [3:0] dig = 4'h0;
  logic sup = 1'b0;
  logic [15:0] v, d1, a, t;
  integer seed = 15;
  integer miscompares = 0;
  integer total_checks = 0;
  integer n;
  speed_profile_mode i_speed_profile_mode (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .actual_speed_i(act), .dig_in_i(dig),
    .travel_sup_en_i(sup), .ffwd_en_i(1'b1), .rdata_o(rdata), .demand_speed_o(dem),
    .torque_ffwd_o(tq), .pos_zero_o(pz));
  plant_model i_plant_model (.sys_clk_i(sys_clk), .follow_i(follow), .demand_i(dem), .actual_o(act));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] st_exp(input logic b13, input logic b12, input logic b10);
    return {2'b00, b13, b12, 1'b0, b10, 10'h000};
  endfunction : st_exp
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic [3:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] ad);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task step_chk(input logic [15:0] s);
    repeat (3) @(posedge sys_clk);
    #1 d1 = dem;
    @(posedge sys_clk);
    #1 chk(dem - d1, s);
    chk(tq, s);
  endtask : step_chk
  task wait_dem(input logic [15:0] g);
    n = 0;
    while (dem !== g && n < 4000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(dem, g);
  endtask : wait_dem
  task give_verdict;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    a = 16'(($random(seed) & 15) + 1);
    t = 16'h0500 + 16'($random(seed) & 255);
    rd_reg(speed_profile_pkg::OFS_ACCEL);
    chk(v, speed_profile_pkg::RST_ACCEL);
    wr_reg(speed_profile_pkg::OFS_SCALE, 16'h0080);
    wr_reg(speed_profile_pkg::OFS_TARGET, 16'h0040);
    rd_reg(speed_profile_pkg::OFS_TARGET);
    chk(v, 16'h0020);
    wr_reg(speed_profile_pkg::OFS_SCALE, 16'h0100);
    $display("test reset and scaling done");
    wr_reg(speed_profile_pkg::OFS_VWIN_TIME, 16'h0000);
    wr_reg(speed_profile_pkg::OFS_ACCEL, a);
    wr_reg(speed_profile_pkg::OFS_DECEL, 16'h0020);
    wr_reg(speed_profile_pkg::OFS_MODE, 16'h0003);
    wr_reg(speed_profile_pkg::OFS_CTRL, 16'h0008);
    wr_reg(speed_profile_pkg::OFS_TARGET, t);
    step_chk(a);
    wait_dem(t);
    repeat (3) @(posedge sys_clk);
    rd_reg(speed_profile_pkg::OFS_STATUS);
    chk(v & 16'h3400, st_exp(1'b1, 1'b1, 1'b0));
    follow <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd_reg(speed_profile_pkg::OFS_STATUS);
    chk(v & 16'h3400, st_exp(1'b0, 1'b0, 1'b1));
    wr_reg(speed_profile_pkg::OFS_TARGET, -t);
    step_chk(16'hffe0);
    wait_dem(-t);
    wr_reg(speed_profile_pkg::OFS_PROF_TYPE, 16'h0001);
    wr_reg(speed_profile_pkg::OFS_TARGET, 16'(-t + 16'h0070));
    step_chk(16'h0011);
    wait_dem(16'(-t + 16'h0070));
    @(posedge sys_clk);
    dig <= 4'h2;
    sup <= 1'b1;
    wait_dem(16'h0000);
    $display("test speed profile done");
    follow <= 1'b0;
    wr_reg(speed_profile_pkg::OFS_HOME_METHOD, 16'h0025);
    wr_reg(speed_profile_pkg::OFS_MODE, 16'h0006);
    wr_reg(speed_profile_pkg::OFS_CTRL, 16'h0018);
    n = 0;
    #1;
    while (pz !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(16'(pz), 16'h0001);
    @(posedge sys_clk);
    #1 chk(16'(pz), 16'h0000);
    repeat (5) @(posedge sys_clk);
    rd_reg(speed_profile_pkg::OFS_STATUS);
    chk(v & 16'h3400, st_exp(1'b0, 1'b1, 1'b1));
    wr_reg(speed_profile_pkg::OFS_CTRL, 16'h0008);
    wr_reg(speed_profile_pkg::OFS_HOME_METHOD, 16'h0002);
    wr_reg(speed_profile_pkg::OFS_CTRL, 16'h0018);
    repeat (5) @(posedge sys_clk);
    rd_reg(speed_profile_pkg::OFS_STATUS);
    chk(v & 16'h3400, st_exp(1'b1, 1'b0, 1'b1));
    wait_dem(16'h0000);
    $display("test reference run done");
    give_verdict;
  end
endmodule : tb
`default_nettype wire
